/* File: lsd_host.sv */
// Purpose: Host end: AXI4-Lite command register drives the serial link.
// Assumes: One write and one read at a time; data are 32 bits.
// Notes: Writing the command word with both low byte lanes strobed starts a 16-bit send then a latch pulse.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "lsd_regs.svh"
module lsd_host #(
	parameter int HALF_DIV = 4
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	lsd_link_if.host         link,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import lsd_pkg::*;
	initial begin
		if (HALF_DIV < 1 || HALF_DIV > 255) $error("HALF_DIV out of range");
	end
	typedef struct packed {
		lsd_hstate_t st;
		lsd_word_t   word;
		logic [4:0]  bitCnt;
		logic [7:0]  divCnt;
		logic        sck;
		logic        sdo;
		logic        lat;
		logic        awHave;
		logic [3:0]  awAddr;
		logic        wHave;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        awRdy;
		logic        wRdy;
		logic        bValid;
		logic [1:0]  bResp;
		logic        arRdy;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
		logic [1:0]  soSync;
	} lsd_host_t;
	lsd_host_t cur_ff;
	lsd_host_t nxt_cur;
	logic tick;
	// Bus slave and serial sequencer in one next-state process.
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.soSync = {cur_ff.soSync[0], link.serialOut};
		tick = (cur_ff.divCnt == 8'(HALF_DIV - 1));
		nxt_cur.divCnt = tick ? 8'h00 : cur_ff.divCnt + 8'h01;
		nxt_cur.awRdy = 1'b0;
		nxt_cur.wRdy = 1'b0;
		nxt_cur.arRdy = 1'b0;
		if (s_axi_awvalid && !cur_ff.awHave && !cur_ff.awRdy && !cur_ff.bValid) begin
			nxt_cur.awRdy = 1'b1;
			nxt_cur.awHave = 1'b1;
			nxt_cur.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !cur_ff.wHave && !cur_ff.wRdy && !cur_ff.bValid) begin
			nxt_cur.wRdy = 1'b1;
			nxt_cur.wHave = 1'b1;
			nxt_cur.wData = s_axi_wdata;
			nxt_cur.wStrb = s_axi_wstrb;
		end
		// A write is held until the serializer is idle, so commands never overlap.
		if (cur_ff.awHave && cur_ff.wHave && cur_ff.st == HS_IDLE) begin
			nxt_cur.awHave = 1'b0;
			nxt_cur.wHave = 1'b0;
			nxt_cur.bValid = 1'b1;
			nxt_cur.bResp = 2'h2;
			if (cur_ff.awAddr == `LSD_ADDR_CMD) begin
				nxt_cur.bResp = 2'h0;
				if (cur_ff.wStrb[1:0] == 2'h3) begin
					nxt_cur.word = cur_ff.wData[15:0];
					nxt_cur.st = HS_SHIFT;
					nxt_cur.bitCnt = 5'h00;
					nxt_cur.divCnt = 8'h00;
				end
			end
		end
		if (cur_ff.bValid && s_axi_bready) begin
			nxt_cur.bValid = 1'b0;
		end
		if (s_axi_arvalid && !cur_ff.rValid && !cur_ff.arRdy) begin
			nxt_cur.arRdy = 1'b1;
			nxt_cur.rValid = 1'b1;
			nxt_cur.rResp = 2'h0;
			if (s_axi_araddr == `LSD_ADDR_CMD) begin
				nxt_cur.rData = {16'h0000, cur_ff.word};
			end else if (s_axi_araddr == `LSD_ADDR_STAT) begin
				nxt_cur.rData = {30'h0, cur_ff.soSync[1], cur_ff.st != HS_IDLE};
			end else begin
				nxt_cur.rData = 32'h0;
				nxt_cur.rResp = 2'h2;
			end
		end
		if (cur_ff.rValid && s_axi_rready) begin
			nxt_cur.rValid = 1'b0;
		end
		// Serial sequencer: data change on clock low, device shifts on the rise.
		unique case (cur_ff.st)
			HS_IDLE: begin
				nxt_cur.sck = 1'b0;
				nxt_cur.lat = 1'b0;
			end
			HS_SHIFT: begin
				if (tick) begin
					if (!cur_ff.sck) begin
						if (cur_ff.bitCnt == 5'(`LSD_WORD_BITS)) begin
							nxt_cur.st = HS_LATCH;
							nxt_cur.lat = 1'b1;
						end else begin
							nxt_cur.sdo = cur_ff.word[4'(15 - cur_ff.bitCnt)];
							nxt_cur.sck = 1'b1;
						end
					end else begin
						nxt_cur.sck = 1'b0;
						nxt_cur.bitCnt = cur_ff.bitCnt + 5'h01;
					end
				end
				if (tick && !cur_ff.sck && cur_ff.bitCnt != 5'(`LSD_WORD_BITS)) begin
					nxt_cur.sck = 1'b0;
					nxt_cur.st = HS_DONE;
				end
			end
			HS_DONE: begin
				// Clock rises one half period after data settle.
				if (tick) begin
					nxt_cur.sck = 1'b1;
					nxt_cur.st = HS_SHIFT;
				end
			end
			HS_LATCH: begin
				if (tick) begin
					nxt_cur.lat = 1'b0;
					nxt_cur.st = HS_IDLE;
				end
			end
		endcase
	end
	// State register.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur_ff <= '0;
			cur_ff.st <= HS_IDLE;
		end else begin
			cur_ff <= nxt_cur;
		end
	end
	assign link.serialClk = cur_ff.sck;
	assign link.serialIn = cur_ff.sdo;
	assign link.latchStrobe = cur_ff.lat;
	assign s_axi_awready = cur_ff.awRdy;
	assign s_axi_wready = cur_ff.wRdy;
	assign s_axi_bvalid = cur_ff.bValid;
	assign s_axi_bresp = cur_ff.bResp;
	assign s_axi_arready = cur_ff.arRdy;
	assign s_axi_rvalid = cur_ff.rValid;
	assign s_axi_rdata = cur_ff.rData;
	assign s_axi_rresp = cur_ff.rResp;
endmodule

/* File: lsd_regs.svh */
// Purpose: Constants for the serial LED driver pair.
// Assumes: Included by both ends.
// Notes: Definitions only.
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH
`define LSD_WORD_BITS     16
`define LSD_MODE_BLANK    4'h0
`define LSD_MODE_NORMAL   4'h1
`define LSD_MODE_LOAD     4'h2
`define LSD_MODE_ALLON    4'h3
`define LSD_MODE_STANDBY  4'h4
`define LSD_SEL_DUTY      4'h0
`define LSD_SEL_DECODE    4'h1
`define LSD_SEL_DIG0      4'h2
`define LSD_SEL_DIG3      4'h5
`define LSD_SBY_KEEP      4'h0
`define LSD_SBY_CLEAR     4'h1
`define LSD_DUTY_INIT     4'hf
`define LSD_DIGITS_INIT   2'h3
`define LSD_DECODE_INIT   1'h1
`define LSD_DATA_INIT     8'h00
`define LSD_SCAN_DIV      8'h3f
`define LSD_HALF_DIV      8'h04
`define LSD_ADDR_CMD      4'h0
`define LSD_ADDR_STAT     4'h4
`endif

/* File: lsd_pkg.sv */
// Purpose: Types shared by the two ends.
// Assumes: Nothing.
// Notes: Constants live in lsd_regs.svh.
package lsd_pkg;
	typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_LATCH, HS_DONE} lsd_hstate_t;
	typedef logic [15:0] lsd_word_t;
endpackage

/* File: lsd_link_if.sv */
// Purpose: Serial link between host controller and LED driver.
// Assumes: All signals are plain one-way wires.
// Notes: No clocking block; the bench joins the ends.
`timescale 1ns/100ps
interface lsd_link_if;
	logic serialClk;
	logic serialIn;
	logic latchStrobe;
	logic serialOut;
	modport host (output serialClk, output serialIn, output latchStrobe, input serialOut);
	modport device (input serialClk, input serialIn, input latchStrobe, output serialOut);
endinterface

/* File: lsd_device.sv */
// Purpose: LED driver end: shift register, latch decode, modes and digit scan.
// Assumes: Link pins are asynchronous and sampled by core_clk through two flops.
// Notes: Character table covers all hex codes 0-F; codes with bit 4 or 5 set blank every segment but the bit-6 decimal point.
`timescale 1ns/100ps
`include "lsd_regs.svh"
module lsd_device #(
	parameter int SCAN_DIV = 64
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	lsd_link_if.device      link,
	output logic [7:0]      segment_sinks,
	output logic [3:0]      digit_sources
);
	import lsd_pkg::*;
	initial begin
		if (SCAN_DIV < 16 || SCAN_DIV > 256) $error("SCAN_DIV out of range");
	end
	typedef struct packed {
		logic [1:0] clkSync;
		logic [1:0] dinSync;
		logic [1:0] latSync;
		logic       clkLast;
		logic       latLast;
		lsd_word_t  shiftReg;
		logic [7:0] selByte;
		logic [3:0] mode;
		logic [3:0] duty;
		logic [1:0] digits;
		logic       decodeOn;
		logic [31:0] dataRegs;
		logic       lit;
		logic [1:0] scanIdx;
		logic [7:0] scanCnt;
		logic       serOut;
		logic [7:0] seg;
		logic [3:0] dig;
	} lsd_dev_t;
	lsd_dev_t cur_ff;
	lsd_dev_t nxt_cur;
	logic [7:0] curData;
	logic [7:0] decoded;
	logic [7:0] dutyLimit;
	// Small character generator for decoded digits; decimal point rides on bit 6.
	always_comb begin
		curData = cur_ff.dataRegs[cur_ff.scanIdx*8 +: 8];
		unique case (curData[3:0])
			4'h0: decoded = 8'h3f;
			4'h1: decoded = 8'h06;
			4'h2: decoded = 8'h5b;
			4'h3: decoded = 8'h4f;
			4'h4: decoded = 8'h66;
			4'h5: decoded = 8'h6d;
			4'h6: decoded = 8'h7d;
			4'h7: decoded = 8'h07;
			4'h8: decoded = 8'h7f;
			4'h9: decoded = 8'h6f;
			4'ha: decoded = 8'h77;
			4'hb: decoded = 8'h7c;
			4'hc: decoded = 8'h39;
			4'hd: decoded = 8'h5e;
			4'he: decoded = 8'h79;
			4'hf: decoded = 8'h71;
		endcase
		if (curData[5:4] != 2'h0) begin
			decoded = 8'h00;
		end
		decoded[7] = curData[6];
		dutyLimit = 8'((int'(cur_ff.duty) * SCAN_DIV) / 16);
	end
	// Next-state logic for the whole device.
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.clkSync = {cur_ff.clkSync[0], link.serialClk};
		nxt_cur.dinSync = {cur_ff.dinSync[0], link.serialIn};
		nxt_cur.latSync = {cur_ff.latSync[0], link.latchStrobe};
		nxt_cur.clkLast = cur_ff.clkSync[1];
		nxt_cur.latLast = cur_ff.latSync[1];
		// Shifting is frozen while latch is high so the pending low byte stays put.
		if (cur_ff.clkSync[1] && !cur_ff.clkLast && !cur_ff.latSync[1]) begin
			nxt_cur.shiftReg = {cur_ff.shiftReg[14:0], cur_ff.dinSync[1]};
		end
		nxt_cur.serOut = cur_ff.shiftReg[15];
		if (cur_ff.latSync[1] && !cur_ff.latLast) begin
			nxt_cur.selByte = cur_ff.shiftReg[15:8];
		end
		if (!cur_ff.latSync[1] && cur_ff.latLast) begin
			unique case (cur_ff.selByte[7:4])
				`LSD_MODE_BLANK: nxt_cur.mode = `LSD_MODE_BLANK;
				`LSD_MODE_NORMAL: begin
					nxt_cur.mode = `LSD_MODE_NORMAL;
					nxt_cur.lit = 1'b1;
				end
				`LSD_MODE_ALLON: nxt_cur.mode = `LSD_MODE_ALLON;
				`LSD_MODE_LOAD: begin
					// Settings land directly in live registers, so Normal shows them at once.
					if (cur_ff.selByte[3:0] == `LSD_SEL_DUTY) begin
						nxt_cur.duty = cur_ff.shiftReg[3:0];
					end else if (cur_ff.selByte[3:0] == `LSD_SEL_DECODE) begin
						nxt_cur.digits = cur_ff.shiftReg[1:0];
						nxt_cur.decodeOn = cur_ff.shiftReg[4];
					end else if (cur_ff.selByte[3:0] <= `LSD_SEL_DIG3) begin
						nxt_cur.dataRegs[(cur_ff.selByte[1:0] - 2'(`LSD_SEL_DIG0))*8 +: 8] =
							cur_ff.shiftReg[7:0];
					end
				end
				`LSD_MODE_STANDBY: begin
					nxt_cur.mode = `LSD_MODE_STANDBY;
					if (cur_ff.shiftReg[3:0] == `LSD_SBY_CLEAR) begin
						nxt_cur.duty = `LSD_DUTY_INIT;
						nxt_cur.digits = `LSD_DIGITS_INIT;
						nxt_cur.decodeOn = `LSD_DECODE_INIT;
						nxt_cur.dataRegs = {4{`LSD_DATA_INIT}};
						nxt_cur.lit = 1'b0;
						nxt_cur.mode = `LSD_MODE_BLANK;
					end
				end
				default: nxt_cur.mode = cur_ff.mode;
			endcase
		end
		// Digit scan: each digit gets one slot, lit for the duty fraction of it.
		nxt_cur.scanCnt = cur_ff.scanCnt + 8'h01;
		if (cur_ff.scanCnt == 8'(SCAN_DIV - 1)) begin
			nxt_cur.scanCnt = 8'h00;
			nxt_cur.scanIdx = (cur_ff.scanIdx >= cur_ff.digits) ? 2'h0 : cur_ff.scanIdx + 2'h1;
		end
		nxt_cur.seg = 8'h00;
		nxt_cur.dig = 4'h0;
		if (cur_ff.lit && cur_ff.scanCnt < dutyLimit && cur_ff.scanIdx <= cur_ff.digits) begin
			if (cur_ff.mode == `LSD_MODE_NORMAL) begin
				nxt_cur.dig = 4'h1 << cur_ff.scanIdx;
				nxt_cur.seg = cur_ff.decodeOn ? decoded : curData;
			end else if (cur_ff.mode == `LSD_MODE_ALLON) begin
				nxt_cur.dig = 4'h1 << cur_ff.scanIdx;
				nxt_cur.seg = 8'hff;
			end
		end
	end
	// State register; reset is the power-on clear state.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur_ff <= '0;
			cur_ff.mode <= `LSD_MODE_BLANK;
			cur_ff.duty <= `LSD_DUTY_INIT;
			cur_ff.digits <= `LSD_DIGITS_INIT;
			cur_ff.decodeOn <= `LSD_DECODE_INIT;
		end else begin
			cur_ff <= nxt_cur;
		end
	end
	assign segment_sinks = cur_ff.seg;
	assign digit_sources = cur_ff.dig;
	assign link.serialOut = cur_ff.serOut;
endmodule

/* File: lsd_link_asserts.sv */
// Purpose: Watches the serial link between the two ends.
// Assumes: The device shift register starts at zero after reset.
// Notes: A shadow register mirrors the device shift register.
`timescale 1ns/100ps
module lsd_link_asserts #(
	parameter int HALF_DIV = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic serialClk,
	input wire logic serialIn,
	input wire logic latchStrobe,
	input wire logic serialOut
);
	typedef struct packed {
		logic        sckPrev;
		logic [15:0] shadow;
		logic [4:0]  rises;
		logic [7:0]  latchLen;
	} lsd_chk_t;
	lsd_chk_t st_ff;
	lsd_chk_t nxt_st;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Mirror the shift register; the link clock is sampled, so a rise shows one core cycle late.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sckPrev = serialClk;
		nxt_st.latchLen = latchStrobe ? st_ff.latchLen + 8'h01 : 8'h00;
		if (serialClk && !st_ff.sckPrev) begin
			nxt_st.shadow = {st_ff.shadow[14:0], serialIn};
			nxt_st.rises = st_ff.rises + 5'h01;
		end
		if (latchStrobe) begin
			nxt_st.rises = 5'h00;
		end
	end

	// Registered helper state.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	msb_shift_a: assert property ($fell(serialClk) |-> ##2 serialOut == st_ff.shadow[15])
		else $error("serial out does not follow the shifted word");
	word_length_a: assert property ($rose(latchStrobe) |-> st_ff.rises == 5'h10)
		else $error("latch not after exactly sixteen clocks");
	latch_quiet_a: assert property (latchStrobe |-> !serialClk)
		else $error("link clock high during latch");
	latch_width_a: assert property ($fell(latchStrobe) |-> st_ff.latchLen == 8'(HALF_DIV))
		else $error("latch pulse width wrong");
	data_steady_a: assert property (serialClk |-> $stable(serialIn))
		else $error("data moved while link clock high");
	sck_width_a: assert property ($rose(serialClk) |-> serialClk [*4] ##1 !serialClk)
		else $error("link clock high time wrong");
	out_frozen_a: assert property (latchStrobe && $past(latchStrobe) |-> $stable(serialOut))
		else $error("shift register moved during latch");
	idle_gap_a: assert property ($fell(latchStrobe) |-> !serialClk [*3])
		else $error("link clock too soon after latch");

	frame_c: cover property ($rose(latchStrobe));
	back_c: cover property ($fell(latchStrobe) ##[1:400] $rose(serialClk));
	out_c: cover property ($rose(serialOut));
endmodule

/* File: test_led_driver_serial_mode_control.sv */
// Purpose: Runs both ends back to back and checks the display against a model.
// Assumes: HALF_DIV 4 and SCAN_DIV 16 keep frames and scans short.
// Notes: Commands enter through the host command register at offset 0.
`timescale 1ns/100ps
module test_led_driver_serial_mode_control;
	logic        core_clk;
	logic        rst;
	logic [3:0]  awAddr, arAddr, wStrb, digs;
	logic [31:0] wData, rData;
	logic        awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
	logic [1:0]  bResp, rResp;
	logic [7:0]  segs;
	logic [7:0]  mData [4];
	logic [15:0] mWord;
	int          errTotal, cmpCount, mMode, mDuty, mDigits, mDecode;

	lsd_link_if link ();
	lsd_host #(.HALF_DIV(4)) i_lsd_host (.core_clk(core_clk), .rst(rst), .link(link),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady));
	lsd_device #(.SCAN_DIV(16)) i_lsd_device (.core_clk(core_clk), .rst(rst), .link(link),
		.segment_sinks(segs), .digit_sources(digs));
	lsd_link_asserts #(.HALF_DIV(4)) i_lsd_link_asserts (.core_clk(core_clk), .rst(rst),
		.serialClk(link.serialClk), .serialIn(link.serialIn), .latchStrobe(link.latchStrobe),
		.serialOut(link.serialOut));

	// Free-running core clock.
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Counts: %0d compares, %0d mismatches", cmpCount, errTotal);
		if (errTotal == 0 && cmpCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Every handshake and busy-poll loop goes through here so a hang ends the run.
	task automatic tick(inout int n);
		@(posedge core_clk);
		n++;
		if (n > 3000) begin
			errTotal++;
			wrap_up();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		awAddr <= a;
		wData <= d;
		wStrb <= s;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			tick(n);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
		end while (!bValid);
		r = bResp;
		bReady <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			tick(n);
			if (arValid && arReady) arValid <= 1'b0;
		end while (!rValid);
		d = rData;
		r = rResp;
		rReady <= 1'b0;
	endtask

	function automatic void init();
		mMode = 0;
		mDuty = 15;
		mDigits = 3;
		mDecode = 1;
		mData = '{default: 8'h00};
	endfunction

	// Reference behaviour of one latched word; undefined codes change nothing.
	function automatic void model(input logic [15:0] w);
		if (w[15:12] inside {4'h0, 4'h1, 4'h3}) mMode = int'(w[15:12]);
		if (w[15:12] == 4'h2 && w[11:8] == 4'h0) mDuty = int'(w[3:0]);
		if (w[15:12] == 4'h2 && w[11:8] == 4'h1) mDecode = int'(w[4]);
		if (w[15:12] == 4'h2 && w[11:8] == 4'h1) mDigits = int'(w[1:0]);
		if (w[15:12] == 4'h2 && w[11:8] inside {[4'h2:4'h5]}) mData[w[9:8] - 2'h2] = w[7:0];
		if (w[15:12] == 4'h4 && w[3:0] == 4'h0) mMode = 4;
		if (w[15:12] == 4'h4 && w[3:0] == 4'h1) init();
	endfunction

	// A write strobe without both low byte lanes is accepted but never sent, so the model stays put.
	task automatic send(input logic [15:0] w, input logic [3:0] s = 4'hf);
		logic [1:0]  r;
		logic [31:0] st;
		int          n;
		n = 0;
		wr(4'h0, {16'h0000, w}, s, r);
		cmp(r, 2'b00);
		if (s[1:0] == 2'b11) begin
			model(w);
			mWord = w;
		end
		do begin
			rd(4'h4, st, r);
			tick(n);
		end while (st[0]);
		cmp(st[1], mWord[15]);
		repeat (16) @(posedge core_clk);
	endtask

	task automatic observe(input string name);
		logic [3:0] seen, last, want;
		logic [7:0] segAny;
		logic [7:0] segOr [4];
		int         i, mask;
		seen = 4'h0;
		last = 4'h0;
		segAny = 8'h00;
		segOr = '{default: 8'h00};
		mask = (mMode == 1 && mDuty != 0) ? (1 << (mDigits + 1)) - 1 : 0;
		repeat (400) begin
			@(posedge core_clk);
			segAny |= segs;
			if (!$onehot0(digs)) cmp(digs, 4'h0);
			want = (last == 4'(1 << mDigits)) ? 4'h1 : last << 1;
			if (digs != 4'h0 && last != 4'h0 && digs != last) cmp(digs, want);
			if (digs != 4'h0) last = digs;
			for (i = 0; i < 4; i++) if (digs[i]) seen[i] = 1'b1;
			for (i = 0; i < 4; i++) if (digs[i]) segOr[i] |= segs;
		end
		if (mMode == 3) cmp(segAny, 8'hff);
		else cmp(seen, mask);
		if (mMode inside {0, 4}) cmp(segAny, 8'h00);
		for (i = 0; i < 4; i++) if (seen[i]) cmp(segOr[i], mMode == 3 ? 8'hff : mDecode ? 8'h3f : mData[i]);
		$display("Test %0s done at %0t", name, $time);
	endtask

	// Main sequence; the model is updated as each word goes out.
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          k;
		rst = 1'b1;
		{awValid, wValid, bReady, arValid, rReady} = 5'h00;
		{awAddr, arAddr, wStrb, wData} = '0;
		errTotal = 0;
		cmpCount = 0;
		mWord = 16'h0000;
		init();
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		void'($urandom(32'ha75ffff9));
		observe("reset");
		send(16'h1000);
		observe("normal default");
		send(16'h2103);
		for (k = 0; k < 4; k++) send({4'h2, 4'(k + 2), 8'($urandom)});
		observe("load while normal");
		send(16'h2101);
		observe("two digits");
		send(16'h0fff);
		observe("blank");
		send(16'h3fff);
		observe("all on");
		send(16'h1abc);
		observe("resume");
		send(16'h2000);
		observe("duty zero");
		send(16'h200f);
		send(16'h4000);
		observe("standby keep");
		send(16'h1000);
		observe("after standby");
		send(16'h8abc);
		observe("undefined mode");
		send(16'h4001);
		observe("clear");
		send(16'h2101, 4'h4);
		send(16'h1000);
		observe("cleared defaults");
		wr(4'h8, 32'h0000_0000, 4'hf, r);
		cmp(r, 2'b10);
		rd(4'h8, d, r);
		cmp(d, 32'h0000_0000);
		cmp(r, 2'b10);
		rd(4'h0, d, r);
		cmp(d[15:0], 16'h1000);
		$display("Test registers done at %0t", $time);
		wrap_up();
	end
endmodule
